// file: angle_spi_pkg.sv
// What this block does
// (R01) Mode 0 and mode 3 detected without setup.
// (R02) Launch on falling edge, sample on rising.
// (R03) Serial clock up to 25MHz, no minimum.
// (R04) Master sends every command as sixteen bits.
// (R05) Reply words are sixteen bits per frame.
// (R06) Seventeenth clock returns a parity bit.
// (R07) Master idles 150ns between angle frames.
// (R08) Master idles 750ns around register reads.
// (R09) Master waits 20ms after a write.
// (R10) Angle read, register read, register write.
// (R11) Fresh angle every microsecond.
// (R12) Direction and zero offset are programmable.
// (R13) Select low freezes angle, high releases.
// (R14) Read 010: value in next frame's upper byte.
// (R15) Write 100: next frame echoes stored value.
// (R16) Unused low angle bits read as zero.
// (R17) Output line released while select is high.
package angle_spi_pkg;
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned CNT_BITS = 5;
    localparam logic [CNT_BITS-1:0] FRAME_LAST = 5'h0f;
    localparam logic [CNT_BITS-1:0] PARITY_POS = 5'h10;
    localparam logic [CNT_BITS-1:0] CNT_MAX = 5'h11;
    localparam int unsigned REG_COUNT = 32;
    localparam logic [2:0] OP_READ = 3'h2;
    localparam logic [2:0] OP_WRITE = 3'h4;
    localparam logic [4:0] REG_ZERO_LO = 5'h00;
    localparam logic [4:0] REG_ZERO_HI = 5'h01;
    localparam logic [4:0] REG_DIR = 5'h09;
    localparam int unsigned DIR_BIT = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int unsigned REF_PERIOD_NS = 100;
    localparam int unsigned REFRESH_NS = 1000;
    localparam int unsigned REFRESH_CYCLES = REFRESH_NS / REF_PERIOD_NS;
    localparam int unsigned NVM_WAIT_NS = 20000000;
    localparam int unsigned NVM_WAIT_CYCLES = (NVM_WAIT_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

    typedef struct packed {
        logic [2:0] op;
        logic [4:0] addr;
        logic [7:0] data;
    } cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_NVM = 2'b10
    } nvm_state_t;
endpackage

// file: bit_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser; only the second stage is visible.
module bit_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_ff <= INIT;
            sync_ff <= INIT;
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule

// file: spi_link_shift.sv
`timescale 1ns/1ps
// Serial clock domain. Chip select high holds the shifter in reset, so no
// edge is needed outside a frame.
module spi_link_shift (
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic link_rst_i,
    input wire logic mosi_i,
    input wire logic [angle_spi_pkg::WORD_BITS-1:0] tx_word_i,
    output logic miso_o,
    output logic miso_oe_o,
    output angle_spi_pkg::cmd_t rx_cmd_o,
    output logic rx_tgl_o
);
    logic [angle_spi_pkg::CNT_BITS-1:0] rise_cnt_ff;
    logic [angle_spi_pkg::CNT_BITS-1:0] bit_idx_ff;
    logic [angle_spi_pkg::WORD_BITS-1:0] shift_ff;
    angle_spi_pkg::cmd_t rx_cmd_ff;
    logic rx_tgl_ff;
    wire frame_end = (rise_cnt_ff == angle_spi_pkg::FRAME_LAST);
    wire [angle_spi_pkg::WORD_BITS-1:0] nxt_shift = {shift_ff[14:0], mosi_i};
    wire [3:0] tx_pos = 4'hf - bit_idx_ff[3:0];
    wire tx_parity = ^tx_word_i;

    // Rising edges count and sample the input line. [R02] [R03]
    always_ff @(posedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            rise_cnt_ff <= '0;
            shift_ff <= '0;
        end
        else
        begin
            shift_ff <= nxt_shift;
            if (rise_cnt_ff != angle_spi_pkg::CNT_MAX)
            begin
                rise_cnt_ff <= rise_cnt_ff + 5'h01;
            end
        end
    end

    // The word is handed over only after exactly sixteen input bits. [R04]
    always_ff @(posedge sclk_i or posedge link_rst_i)
    begin
        if (link_rst_i)
        begin
            rx_cmd_ff <= '0;
            rx_tgl_ff <= 1'b0;
        end
        else if (frame_end)
        begin
            rx_cmd_ff <= nxt_shift;
            rx_tgl_ff <= ~rx_tgl_ff;
        end
    end

    // The output index follows the rising count on falling edges; in mode 3
    // the first falling edge keeps the first bit, so both modes line up. [R01] [R02]
    always_ff @(negedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            bit_idx_ff <= '0;
        end
        else
        begin
            bit_idx_ff <= rise_cnt_ff;
        end
    end

    // Sixteen data bits, then parity, then zero. [R05] [R06]
    assign miso_o = (bit_idx_ff < angle_spi_pkg::PARITY_POS) ? tx_word_i[tx_pos]
                  : (bit_idx_ff == angle_spi_pkg::PARITY_POS) ? tx_parity : 1'b0;
    assign miso_oe_o = ~cs_n_i; // [R17]
    assign rx_cmd_o = rx_cmd_ff;
    assign rx_tgl_o = rx_tgl_ff;

    a_miso_release: assert property (@(posedge sclk_i) cs_n_i |-> !miso_oe_o) // [R17]
        else $error("Output enabled while select high.");
endmodule

// file: angle_spi_top.sv
`timescale 1ns/1ps
// Reference clock side: angle refresh and conditioning, register store with
// the non-volatile write delay, and selection of the reply word.
module angle_spi_top #(
    parameter int unsigned ANGLE_BITS = 16,
    parameter int unsigned NVM_CYCLES = angle_spi_pkg::NVM_WAIT_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [angle_spi_pkg::WORD_BITS-1:0] angle_raw_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic nvm_busy_o,
    output logic [angle_spi_pkg::WORD_BITS-1:0] angle_o
);
    localparam int unsigned RC_BITS = $clog2(angle_spi_pkg::REFRESH_CYCLES + 1);
    localparam int unsigned NC_BITS = $clog2(NVM_CYCLES + 1);
    localparam logic [RC_BITS-1:0] RC_LAST = RC_BITS'(angle_spi_pkg::REFRESH_CYCLES - 1);
    localparam logic [NC_BITS-1:0] NC_LAST = NC_BITS'(NVM_CYCLES - 1);
    localparam logic [angle_spi_pkg::WORD_BITS-1:0] RES_MASK =
        ~((16'h0001 << (angle_spi_pkg::WORD_BITS - ANGLE_BITS)) - 16'h0001);

    function automatic logic [15:0] condition_angle(
        input logic [15:0] raw,
        input logic ccw,
        input logic [15:0] zero
    );
        logic [15:0] dir_raw;
        dir_raw = ccw ? (16'h0000 - raw) : raw;
        return (dir_raw - zero) & RES_MASK;
    endfunction

    logic [7:0] reg_ff [angle_spi_pkg::REG_COUNT];
    logic [RC_BITS-1:0] refresh_cnt_ff;
    logic [NC_BITS-1:0] nvm_cnt_ff;
    logic [15:0] angle_ff;
    logic [15:0] tx_word_ff;
    logic reply_reg_ff;
    logic [4:0] reply_addr_ff;
    logic tgl_seen_ff;
    angle_spi_pkg::cmd_t wr_cmd_ff;
    angle_spi_pkg::nvm_state_t state_ff;
    angle_spi_pkg::nvm_state_t nxt_state;
    angle_spi_pkg::cmd_t rx_cmd;
    logic rx_tgl;
    logic rx_tgl_sync;
    logic cs_n_sync;
    angle_spi_pkg::cmd_t rx_cmd_sync;

    spi_link_shift u_link (
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .link_rst_i(sys_rst_i),
        .mosi_i(mosi_i),
        .tx_word_i(tx_word_ff),
        .miso_o(miso_o),
        .miso_oe_o(miso_oe_o),
        .rx_cmd_o(rx_cmd),
        .rx_tgl_o(rx_tgl)
    );

    bit_sync #(.WIDTH(2), .INIT(2'b11)) u_sync_ctl (
        .clk_i(ref_clk_i),
        .rst_i(sys_rst_i),
        .async_i({cs_n_i, rx_tgl}),
        .sync_o({cs_n_sync, rx_tgl_sync})
    );

    // The command word is stable long before its toggle arrives here, and it
    // is only read on the toggle edge.
    assign rx_cmd_sync = rx_cmd;

    wire frame_evt = rx_tgl_sync ^ tgl_seen_ff;
    wire is_read = frame_evt && (rx_cmd_sync.op == angle_spi_pkg::OP_READ);
    wire is_write = frame_evt && (rx_cmd_sync.op == angle_spi_pkg::OP_WRITE);
    wire refresh_tick = (refresh_cnt_ff == RC_LAST);
    wire nvm_done = (state_ff == angle_spi_pkg::ST_NVM) && (nvm_cnt_ff == NC_LAST);
    wire [15:0] zero_ref = {reg_ff[angle_spi_pkg::REG_ZERO_HI],
                            reg_ff[angle_spi_pkg::REG_ZERO_LO]};
    wire dir_ccw = reg_ff[angle_spi_pkg::REG_DIR][angle_spi_pkg::DIR_BIT];
    wire [15:0] nxt_angle = condition_angle(angle_raw_i, dir_ccw, zero_ref);
    wire [15:0] reg_reply = {reg_ff[reply_addr_ff], 8'h00};
    wire [15:0] nxt_tx = reply_reg_ff ? reg_reply : angle_ff;
    wire tx_hold = ~cs_n_sync;

    // A fresh angle every microsecond, conditioned by direction and zero. [R11] [R12] [R16]
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            refresh_cnt_ff <= '0;
            angle_ff <= '0;
        end
        else
        begin
            refresh_cnt_ff <= refresh_tick ? '0 : refresh_cnt_ff + RC_BITS'(1);
            if (refresh_tick)
            begin
                angle_ff <= nxt_angle;
            end
        end
    end

    // Next-frame reply: register commands select a register reply for one
    // frame, anything else returns to angle. [R10] [R14] [R15]
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            tgl_seen_ff <= 1'b0;
            reply_reg_ff <= 1'b0;
            reply_addr_ff <= '0;
        end
        else
        begin
            tgl_seen_ff <= rx_tgl_sync;
            if (frame_evt)
            begin
                reply_reg_ff <= is_read | is_write;
                reply_addr_ff <= rx_cmd_sync.addr;
            end
        end
    end

    // The output word is frozen while select is low. [R13]
    // Select reaches this side one to two cycles late, so a refresh in that
    // span can still change the word while the first bits go out.
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            tx_word_ff <= '0;
        end
        else if (!tx_hold)
        begin
            tx_word_ff <= nxt_tx;
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            angle_spi_pkg::ST_IDLE:
            begin
                if (is_write)
                begin
                    nxt_state = angle_spi_pkg::ST_NVM;
                end
            end
            angle_spi_pkg::ST_NVM:
            begin
                if (nvm_done)
                begin
                    nxt_state = angle_spi_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = angle_spi_pkg::ST_IDLE;
            end
        endcase
    end

    // The store lands only after the write delay; until then the old value
    // reads back. A write during the delay is ignored. [R09] [R15]
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_ff <= angle_spi_pkg::ST_IDLE;
            nvm_cnt_ff <= '0;
            wr_cmd_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            nvm_cnt_ff <= (state_ff == angle_spi_pkg::ST_NVM) ? nvm_cnt_ff + NC_BITS'(1) : '0;
            if (is_write && state_ff == angle_spi_pkg::ST_IDLE)
            begin
                wr_cmd_ff <= rx_cmd_sync;
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < angle_spi_pkg::REG_COUNT; i++)
            begin
                reg_ff[i] <= angle_spi_pkg::REG_RESET;
            end
        end
        else if (nvm_done)
        begin
            reg_ff[wr_cmd_ff.addr] <= wr_cmd_ff.data;
        end
    end

    assign nvm_busy_o = (state_ff == angle_spi_pkg::ST_NVM);
    assign angle_o = angle_ff;

    // Counts the cycles of each store delay on its own, so that the delay
    // length is checked apart from the store's own counter.
    logic [NC_BITS-1:0] busy_len_ff;

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i || !nvm_busy_o)
        begin
            busy_len_ff <= '0;
        end
        else
        begin
            busy_len_ff <= busy_len_ff + NC_BITS'(1);
        end
    end

    // Checks on the reference clock side.
    a_refresh_gap: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R11]
        refresh_tick |=> !refresh_tick [*8] ##1 !refresh_tick)
        else $error("Angle refresh came early.");

    a_refresh_next: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R11]
        refresh_tick |-> ##10 refresh_tick)
        else $error("Angle refresh not every ten cycles.");

    a_angle_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R11]
        !refresh_tick |=> $stable(angle_ff))
        else $error("Angle changed between refreshes.");

    a_angle_cond: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R12]
        refresh_tick |=> angle_ff == $past(nxt_angle))
        else $error("Angle not conditioned by direction and zero.");

    a_angle_pad: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R16]
        (angle_ff & ~RES_MASK) == 16'h0000)
        else $error("Unused angle bits not zero.");

    a_reply_pad: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R16]
        !reply_reg_ff && !tx_hold |=> (tx_word_ff & ~RES_MASK) == 16'h0000)
        else $error("Unused bits of angle reply not zero.");

    a_tx_freeze: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R13]
        tx_hold && $past(tx_hold) |-> $stable(tx_word_ff))
        else $error("Output word changed while select low.");

    a_angle_follow: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R13]
        !reply_reg_ff && !tx_hold |=> tx_word_ff == $past(angle_ff))
        else $error("Released output word does not follow angle.");

    a_read_reply: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R14]
        is_read |=> reply_reg_ff && reply_addr_ff == $past(rx_cmd_sync.addr))
        else $error("Read command did not select register reply.");

    a_read_no_store: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R14]
        is_read && !nvm_busy_o |=> !nvm_busy_o)
        else $error("Read command started a store.");

    a_reply_low: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R14]
        reply_reg_ff && !tx_hold |=> tx_word_ff[7:0] == 8'h00)
        else $error("Register reply low byte not zero.");

    a_reg_follow: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R14]
        reply_reg_ff && !tx_hold |=> tx_word_ff[15:8] == $past(reg_ff[reply_addr_ff]))
        else $error("Register reply upper byte not the register.");

    a_write_reply: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R15]
        is_write |=> reply_reg_ff && reply_addr_ff == $past(rx_cmd_sync.addr))
        else $error("Write command did not select register echo.");

    a_write_store: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R15]
        nvm_done |=> reg_ff[$past(wr_cmd_ff.addr)] == $past(wr_cmd_ff.data))
        else $error("Write value not stored after delay.");

    a_write_start: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R15]
        is_write && state_ff == angle_spi_pkg::ST_IDLE |=> nvm_busy_o [*3])
        else $error("Write did not start the store delay.");

    a_store_cause: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R15]
        $rose(nvm_busy_o) |-> $past(is_write))
        else $error("Store delay began without a write.");

    a_nvm_length: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R09]
        $fell(nvm_busy_o) |-> $past(busy_len_ff) == NC_LAST)
        else $error("Store delay of wrong length.");

    a_write_ignored: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R09]
        is_write && nvm_busy_o |=> $stable(wr_cmd_ff))
        else $error("Write during store delay was taken.");

    a_store_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R09]
        !nvm_done |=> $stable(zero_ref) && $stable(dir_ccw))
        else $error("Settings changed outside a store.");

    a_angle_reply: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R10]
        frame_evt && !is_read && !is_write |=> !reply_reg_ff)
        else $error("Angle frame did not restore angle reply.");
endmodule

// file: spi_master_model.sv
`timescale 1ns/1ps
// Behavioural SPI master; outside a frame its serial clock moves only to the idle level of the next frame's mode.
module spi_master_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic miso_oe_i
);
    localparam int HALF_NS = 24;
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Shifts cmd out MSB first and gathers nbits reply bits, newest in bit 0.
    task automatic frame(input logic mode3, input int nbits, input logic [15:0] cmd,
                         input int hold_ns, output logic [16:0] rx);
        int i;
        rx = '0;
        sclk_o = mode3;
        #(HALF_NS * 4);
        cs_n_o = 1'b0;
        #(hold_ns + HALF_NS * 4);
        for (i = 0; i < nbits; i++)
        begin
            sclk_o = 1'b0;
            mosi_o = (i < 16) ? cmd[15 - i] : ~mosi_o;
            #(HALF_NS);
            rx = {rx[15:0], miso_oe_i ? miso_i : ~rx[0]};
            sclk_o = 1'b1;
            #(HALF_NS);
        end
        sclk_o = mode3;
        #(HALF_NS * 2);
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
        #1000;
    endtask
endmodule

// file: angle_sensor_spi_slave_tb.sv
`timescale 1ns/1ps
module angle_sensor_spi_slave_tb;
    localparam logic [15:0] MASK = 16'hfff0;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] angle_raw = 16'h0000;
    wire logic sclk;
    wire logic cs_n;
    wire logic mosi;
    wire logic miso;
    wire logic miso_oe;
    wire logic nvm_busy;
    wire logic [15:0] angle;
    int err_total = 0;
    int compares = 0;
    logic [16:0] rx;
    always #50 ref_clk = ~ref_clk;
    angle_spi_top #(.ANGLE_BITS(12), .NVM_CYCLES(40)) u_dut (
        .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .angle_raw_i(angle_raw),
        .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
        .miso_oe_o(miso_oe), .nvm_busy_o(nvm_busy), .angle_o(angle));
    spi_master_model u_master (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
        .miso_i(miso), .miso_oe_i(miso_oe));
    task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic m3, input int n, input logic [15:0] cmd, input int hold);
        u_master.frame(m3, n, cmd, hold, rx);
        check("miso_oe idle", 17'h0, {16'h0, miso_oe});
    endtask
    task automatic set_raw(input logic [15:0] v);
        @(negedge ref_clk);
        angle_raw <= v;
        repeat (15) @(negedge ref_clk);
    endtask
    task automatic test_modes;
        int m;
        set_raw(16'h1234);
        check("angle_o", {1'b0, 16'h1234 & MASK}, {1'b0, angle});
        for (m = 0; m < 2; m++)
        begin
            xfer(m[0], 16, 16'h0000, 0);
            check("angle word", {1'b0, 16'h1230}, rx);
            xfer(m[0], 17, 16'h0000, 0);
            check("angle parity", {16'h1230, ^16'h1230}, rx);
        end
        $display("test modes done");
    endtask
    task automatic test_freeze;
        int i;
        set_raw(16'h4321);
        fork
            xfer(1'b0, 16, 16'h0000, 2000);
            begin
                #600;
                @(negedge ref_clk);
                angle_raw <= 16'h0abc;
            end
        join
        check("frozen angle", {1'b0, 16'h4320}, rx);
        for (i = 0; i < 12 && angle !== 16'h0ab0; i++) @(negedge ref_clk);
        check("refreshed angle_o", {1'b0, 16'h0ab0}, {1'b0, angle});
        xfer(1'b0, 16, 16'h0000, 0);
        check("released angle", {1'b0, 16'h0ab0}, rx);
        $display("test freeze done");
    endtask
    task automatic wait_store;
        int i;
        for (i = 0; i < 100 && nvm_busy !== 1'b0; i++) @(negedge ref_clk);
        check("nvm_busy done", 17'h0, {16'h0, nvm_busy});
    endtask
    task automatic test_regs;
        xfer(1'b0, 16, {angle_spi_pkg::OP_WRITE, angle_spi_pkg::REG_DIR, 8'h80}, 0);
        check("nvm_busy", 17'h1, {16'h0, nvm_busy});
        xfer(1'b1, 16, {angle_spi_pkg::OP_WRITE, angle_spi_pkg::REG_ZERO_LO, 8'h55}, 0);
        check("old value", {1'b0, 16'h0000}, rx);
        wait_store();
        xfer(1'b0, 16, {angle_spi_pkg::OP_WRITE, angle_spi_pkg::REG_DIR, 8'h80}, 0);
        check("ignored write", {1'b0, 16'h0000}, rx);
        wait_store();
        xfer(1'b0, 16, 16'h0000, 0);
        check("write echo", {1'b0, 16'h8000}, rx);
        xfer(1'b0, 16, {angle_spi_pkg::OP_READ, angle_spi_pkg::REG_ZERO_LO, 8'h00}, 0);
        check("reversed angle", {1'b0, (16'h0 - 16'h0abc) & MASK}, rx);
        xfer(1'b1, 16, {3'h7, 5'h03, 8'h00}, 0);
        check("read ignored write", {1'b0, 16'h0000}, rx);
        xfer(1'b1, 16, {angle_spi_pkg::OP_READ, angle_spi_pkg::REG_DIR, 8'h00}, 0);
        check("unknown op angle", {1'b0, (16'h0 - 16'h0abc) & MASK}, rx);
        xfer(1'b1, 17, 16'h0000, 0);
        check("read dir parity", {16'h8000, 1'b1}, rx);
        $display("test regs done");
    endtask
    task automatic finish_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial
    begin
        repeat (6) @(negedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(negedge ref_clk);
        test_modes();
        test_freeze();
        test_regs();
        finish_test();
    end
    // The tests take well under 100 us; a hang is cut off at 1 ms.
    initial
    begin
        #1000000;
        err_total++;
        finish_test();
    end
endmodule
